// *** acl_regs.vh ***
`ifndef ACL_REGS_VH
`define ACL_REGS_VH

// register byte offsets, one aligned word each
`define ACL_OFS_CONTROL      8'h00
`define ACL_OFS_FREQ         8'h04
`define ACL_OFS_ENABLE       8'h08
`define ACL_OFS_AMPLITUDE    8'h0c
`define ACL_OFS_FLAGS        8'h10
`define ACL_OFS_IRQ_STATUS   8'h14
`define ACL_OFS_IRQ_CLEAR    8'h18
`define ACL_OFS_IRQ_ENABLE   8'h1c

// lead_off_control fields
`define ACL_CTL_SHUTDOWN     0
`define ACL_CTL_AC_SEL       1
`define ACL_CTL_ANALOG_SEL   2
`define ACL_CTL_LEVEL_LO     3
`define ACL_CTL_LEVEL_HI     4

// excitation_frequency_control fields
`define ACL_FRQ_DIV_HI       6
`define ACL_FRQ_PRESCALE     7

// reset values
`define ACL_RST_CONTROL      5'h00
`define ACL_RST_FREQ         8'h00
`define ACL_RST_ENABLE       6'h00
`define ACL_RST_AMPLITUDE    8'h00
`define ACL_RST_IRQ_ENABLE   6'h00

// timing: divider base rate and core clock, both in kHz
`define ACL_BASE_FREQ_KHZ    50
`define ACL_CORE_FREQ_KHZ    20000
`define ACL_BASE_CYCLES      (`ACL_CORE_FREQ_KHZ / `ACL_BASE_FREQ_KHZ)

`endif

// *** acl_exc_div.v ***
`timescale 1ns/10ps
`default_nettype none

`include "acl_regs.vh"

module acl_exc_div
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire       run,
	input  wire [6:0] divisor,
	input  wire       prescale_sel,
	output reg        phase
);

	// base count held as an integer, then cut to the counter width on purpose
	localparam integer BASE_CYCLES = `ACL_BASE_CYCLES;
	localparam [8:0]   BASE_LAST   = BASE_CYCLES[8:0] - 9'h001;

	reg  [8:0]  base_cnt;
	reg  [12:0] half_cnt;
	reg  [7:0]  last_cfg;
	wire [7:0]  steps;
	wire [12:0] half_len;
	wire [12:0] half_last;
	wire        cfg_changed;
	wire        base_tick;

	// half period = 2*K*(divisor+1) ticks of the 50 kHz base
	assign steps     = {1'b0, divisor} + 8'h01;
	assign half_len  = prescale_sel ? {steps, 5'h00} : {4'h0, steps, 1'b0};
	assign half_last = half_len - 13'h0001;
	assign cfg_changed = {prescale_sel, divisor} != last_cfg;
	assign base_tick = base_cnt == BASE_LAST;

	// restart from phase zero on any setting change, so no runt low phase
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			base_cnt <= 9'h000;
			half_cnt <= 13'h0000;
			last_cfg <= 8'h00;
			phase    <= 1'b0;
		end
		else
		begin
			last_cfg <= {prescale_sel, divisor};
			if (!run || cfg_changed)
			begin
				base_cnt <= 9'h000;
				half_cnt <= 13'h0000;
				phase    <= 1'b0;
			end
			else if (base_tick)
			begin
				base_cnt <= 9'h000;
				if (half_cnt >= half_last)
				begin
					half_cnt <= 13'h0000;
					phase    <= ~phase;
				end
				else
					half_cnt <= half_cnt + 13'h0001;
			end
			else
				base_cnt <= base_cnt + 9'h001;
		end
	end

endmodule

`default_nettype wire

// *** acl_top.v ***
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

`include "acl_regs.vh"

module acl_top
(
	input  wire        CORE_CLK,
	input  wire        RESETN,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire [5:0]  AC_COMPARE,
	input  wire [5:0]  DC_COMPARE,
	output reg  [5:0]  PIN_SOURCE,
	output reg  [5:0]  PIN_SINK,
	output reg  [5:0]  PIN_DC_INJECT,
	output reg  [2:0]  CH_POS_SOURCE,
	output reg  [2:0]  CH_POS_SINK,
	output reg  [2:0]  CH_NEG_SOURCE,
	output reg  [2:0]  CH_NEG_SINK,
	output reg  [7:0]  CURRENT_DAC_CODE,
	output reg  [1:0]  THRESHOLD_DAC_LEVEL,
	output reg         AC_DETECT_EN,
	output reg         DC_DETECT_EN,
	output reg         EXCITATION_PHASE,
	output wire        IRQ
);

	// software-visible state, plus the read-data, address and flag decode temporaries
	reg  [4:0]  lead_off_control;
	reg  [7:0]  excitation_frequency_control;
	reg  [5:0]  test_current_enable;
	reg  [7:0]  test_current_amplitude;
	reg  [5:0]  lead_off_error_flags;
	reg  [5:0]  irq_status;
	reg  [5:0]  irq_enable;
	reg  [31:0] next_prdata;
	reg         addr_ok;
	reg  [5:0]  next_flags;

	wire        wr_en;
	wire        rd_setup;
	wire        detect_block_shutdown;
	wire        ac_mode_select;
	wire        analog_ac_select;
	wire [1:0]  ac_threshold_level;
	wire [6:0]  excitation_divisor;
	wire        divisor_prescale_select;
	wire [5:0]  pin_test_enable;
	wire [7:0]  test_current_code;
	wire        block_active;
	wire        ac_active;
	wire        analog_mode;
	wire        digital_mode;
	wire        dc_mode;
	wire        div_phase;
	wire [2:0]  ch_polarity;
	wire [5:0]  flag_rise;
	wire [5:0]  irq_clear;

	// apb: zero wait states, error only for unmapped offsets
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL & PENABLE & ~addr_ok;
	assign wr_en    = PSEL & PENABLE & PWRITE & addr_ok;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

	// field decode
	assign detect_block_shutdown   = lead_off_control[`ACL_CTL_SHUTDOWN];
	assign ac_mode_select          = lead_off_control[`ACL_CTL_AC_SEL];
	assign analog_ac_select        = lead_off_control[`ACL_CTL_ANALOG_SEL];
	assign ac_threshold_level      = lead_off_control[`ACL_CTL_LEVEL_HI:`ACL_CTL_LEVEL_LO];
	assign excitation_divisor      = excitation_frequency_control[`ACL_FRQ_DIV_HI:0];
	assign divisor_prescale_select = excitation_frequency_control[`ACL_FRQ_PRESCALE];
	assign pin_test_enable         = test_current_enable;
	assign test_current_code       = test_current_amplitude;

	// mode decode; software owns the bit combination
	assign block_active = ~detect_block_shutdown;
	assign ac_active    = block_active & ac_mode_select;
	assign analog_mode  = ac_active & analog_ac_select;
	assign digital_mode = ac_active & ~analog_ac_select;
	assign dc_mode      = block_active & ~ac_mode_select;

	// divider runs only in either AC mode, parked at phase zero otherwise
	acl_exc_div u_div
	(
		.clk          (CORE_CLK),
		.rst_n        (RESETN),
		.run          (ac_active),
		.divisor      (excitation_divisor),
		.prescale_sel (divisor_prescale_select),
		.phase        (div_phase)
	);

	// bits 5:3 invert the divider phase for channels three..one
	assign ch_polarity = {3{div_phase}} ^ pin_test_enable[5:3];

	// address decode and read data, sampled in the setup cycle
	always @*
	begin
		addr_ok     = 1'b1;
		next_prdata = 32'h00000000;
		case (PADDR)
			`ACL_OFS_CONTROL:
				next_prdata = {27'h0000000, lead_off_control};
			`ACL_OFS_FREQ:
				next_prdata = {24'h000000, excitation_frequency_control};
			`ACL_OFS_ENABLE:
				next_prdata = {26'h0000000, test_current_enable};
			`ACL_OFS_AMPLITUDE:
				next_prdata = {24'h000000, test_current_amplitude};
			`ACL_OFS_FLAGS:
				next_prdata = {26'h0000000, lead_off_error_flags};
			`ACL_OFS_IRQ_STATUS:
				next_prdata = {26'h0000000, irq_status};
			`ACL_OFS_IRQ_CLEAR:
				next_prdata = 32'h00000000; // write-only
			`ACL_OFS_IRQ_ENABLE:
				next_prdata = {26'h0000000, irq_enable};
			default:
				addr_ok = 1'b0;
		endcase
	end

	// read data flop, so prdata is stable through the access phase
	always @(posedge CORE_CLK)
	begin
		if (!RESETN)
			PRDATA <= 32'h00000000;
		else if (rd_setup)
			PRDATA <= next_prdata;
	end

	// configuration registers, written at the access edge only
	always @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			lead_off_control             <= `ACL_RST_CONTROL;
			excitation_frequency_control <= `ACL_RST_FREQ;
			test_current_enable          <= `ACL_RST_ENABLE;
			test_current_amplitude       <= `ACL_RST_AMPLITUDE;
			irq_enable                   <= `ACL_RST_IRQ_ENABLE;
		end
		else if (wr_en)
		begin
			case (PADDR)
				`ACL_OFS_CONTROL:
					lead_off_control <= PWDATA[4:0];
				`ACL_OFS_FREQ:
					excitation_frequency_control <= PWDATA[7:0];
				`ACL_OFS_ENABLE:
					test_current_enable <= PWDATA[5:0];
				`ACL_OFS_AMPLITUDE:
					test_current_amplitude <= PWDATA[7:0];
				`ACL_OFS_IRQ_ENABLE:
					irq_enable <= PWDATA[5:0];
				default:
					irq_enable <= irq_enable;
			endcase
		end
	end

	// flag source follows the mode; digital mode reports via channel data
	always @*
	begin
		next_flags = 6'h00;
		if (analog_mode)
			next_flags = pin_test_enable & AC_COMPARE;
		else if (dc_mode)
			next_flags = pin_test_enable & DC_COMPARE;
	end

	// a new lead-off flag raises a sticky event; set beats clear
	assign flag_rise = next_flags & ~lead_off_error_flags;
	assign irq_clear = (wr_en && PADDR == `ACL_OFS_IRQ_CLEAR) ? PWDATA[5:0] : 6'h00;
	assign IRQ       = |(irq_status & irq_enable);

	always @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			lead_off_error_flags <= 6'h00;
			irq_status           <= 6'h00;
		end
		else
		begin
			lead_off_error_flags <= next_flags;
			irq_status           <= (irq_status & ~irq_clear) | flag_rise;
		end
	end

	// analog drive outputs, registered to keep switch controls glitch free
	always @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			PIN_SOURCE          <= 6'h00;
			PIN_SINK            <= 6'h00;
			PIN_DC_INJECT       <= 6'h00;
			CH_POS_SOURCE       <= 3'h0;
			CH_POS_SINK         <= 3'h0;
			CH_NEG_SOURCE       <= 3'h0;
			CH_NEG_SINK         <= 3'h0;
			CURRENT_DAC_CODE    <= 8'h00;
			THRESHOLD_DAC_LEVEL <= 2'h0;
			AC_DETECT_EN        <= 1'b0;
			DC_DETECT_EN        <= 1'b0;
			EXCITATION_PHASE    <= 1'b0;
		end
		else
		begin
			// per pin, source on high phase and sink on low, never both
			PIN_SOURCE <= analog_mode ? (pin_test_enable & {6{div_phase}}) : 6'h00;
			PIN_SINK   <= analog_mode ? (pin_test_enable & {6{~div_phase}}) : 6'h00;
			PIN_DC_INJECT <= dc_mode ? pin_test_enable : 6'h00;
			// balanced channel injection: negative input mirrors positive
			CH_POS_SOURCE <= digital_mode ? (pin_test_enable[2:0] & ch_polarity) : 3'h0;
			CH_POS_SINK   <= digital_mode ? (pin_test_enable[2:0] & ~ch_polarity) : 3'h0;
			CH_NEG_SOURCE <= digital_mode ? (pin_test_enable[2:0] & ~ch_polarity) : 3'h0;
			CH_NEG_SINK   <= digital_mode ? (pin_test_enable[2:0] & ch_polarity) : 3'h0;
			// current code straight to the DAC, zeroed when shut down
			CURRENT_DAC_CODE    <= block_active ? test_current_code : 8'h00;
			THRESHOLD_DAC_LEVEL <= ac_threshold_level;
			AC_DETECT_EN        <= analog_mode;
			DC_DETECT_EN        <= dc_mode;
			EXCITATION_PHASE    <= div_phase;
		end
	end

endmodule

`default_nettype wire

// *** acl_electrodes.sv ***
`timescale 1ns/10ps
`default_nettype none

module acl_electrodes
(
	input  wire logic       clk,
	input  wire logic [5:0] src,
	input  wire logic [5:0] snk,
	input  wire logic [5:0] dc,
	input  wire logic [5:0] off_mask,
	output logic      [5:0] ac_cmp = 6'h00,
	output logic      [5:0] dc_cmp = 6'h00
);
	// a loose lead only shows a large voltage while test current flows into it
	always @(posedge clk)
	begin
		ac_cmp <= off_mask & (src | snk);
		dc_cmp <= off_mask & dc;
	end
endmodule

`default_nettype wire

// *** acl_chk_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module acl_chk
(
	input wire logic       CORE_CLK,
	input wire logic       RESETN,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PREADY,
	input wire logic       PSLVERR,
	input wire logic [5:0] PIN_SOURCE,
	input wire logic [5:0] PIN_SINK,
	input wire logic [2:0] CH_POS_SOURCE,
	input wire logic [2:0] CH_POS_SINK,
	input wire logic [2:0] CH_NEG_SOURCE,
	input wire logic [2:0] CH_NEG_SINK,
	input wire logic       AC_DETECT_EN,
	input wire logic       DC_DETECT_EN,
	input wire logic       EXCITATION_PHASE
);
	logic        last;
	logic [15:0] run;

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	// cycles since the excitation last changed, saturating
	always @(posedge CORE_CLK)
	begin
		last <= RESETN ? EXCITATION_PHASE : 1'b0;
		if (!RESETN || EXCITATION_PHASE != last)
			run <= 16'h0000;
		else if (run != 16'hffff)
			run <= run + 16'h0001;
	end

	ready_const_a: assert property (PREADY) else $error("ready dropped");
	err_access_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
	switch_excl_a: assert property ((PIN_SOURCE & PIN_SINK) == 6'h00) else $error("source and sink");
	neg_mirror_a: assert property (CH_NEG_SOURCE == CH_POS_SINK && CH_NEG_SINK == CH_POS_SOURCE)
		else $error("negative drive not opposite");
	mode_excl_a: assert property (!(AC_DETECT_EN && DC_DETECT_EN)) else $error("two modes");
	pin_idle_a: assert property (!AC_DETECT_EN && !$past(AC_DETECT_EN) |-> (PIN_SOURCE | PIN_SINK) == 6'h00)
		else $error("pin switch outside analog mode");
	chan_idle_a: assert property (AC_DETECT_EN && $past(AC_DETECT_EN) |-> (CH_POS_SOURCE | CH_POS_SINK) == 3'h0)
		else $error("channel drive in analog mode");
	half_len_a: assert property ($rose(EXCITATION_PHASE) |-> run >= 16'd799) else $error("runt low half");

	cover property ($rose(AC_DETECT_EN));
	cover property (CH_POS_SOURCE != 3'h0);
	cover property (PSLVERR);
endmodule

`default_nettype wire

// *** acl_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end

module acl_top_tb;
	logic        CORE_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 8'h00, CURRENT_DAC_CODE;
	logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
	logic        PREADY, PSLVERR, IRQ, AC_DETECT_EN, DC_DETECT_EN, EXCITATION_PHASE, err;
	logic [5:0]  AC_COMPARE, DC_COMPARE, PIN_SOURCE, PIN_SINK, PIN_DC_INJECT, off_mask = 6'h00;
	logic [2:0]  CH_POS_SOURCE, CH_POS_SINK, CH_NEG_SOURCE, CH_NEG_SINK;
	logic [1:0]  THRESHOLD_DAC_LEVEL;
	int          bad_count = 0, samples_checked = 0, cyc = 0, n;

	acl_top acl_top_i (.CORE_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .AC_COMPARE, .DC_COMPARE, .PIN_SOURCE, .PIN_SINK, .PIN_DC_INJECT, .CH_POS_SOURCE,
		.CH_POS_SINK, .CH_NEG_SOURCE, .CH_NEG_SINK, .CURRENT_DAC_CODE, .THRESHOLD_DAC_LEVEL, .AC_DETECT_EN,
		.DC_DETECT_EN, .EXCITATION_PHASE, .IRQ);
	acl_electrodes acl_electrodes_i (.clk(CORE_CLK), .src(PIN_SOURCE), .snk(PIN_SINK), .dc(PIN_DC_INJECT),
		.off_mask, .ac_cmp(AC_COMPARE), .dc_cmp(DC_COMPARE));

	// clock generator
	initial forever #25 CORE_CLK = ~CORE_CLK;

	// hang guard, well above the longest excitation measurement
	always @(posedge CORE_CLK)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			bad_count++;
			finish_test;
		end
	end

	task finish_test;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one apb transfer; the request holds until ready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1;
		do @(posedge CORE_CLK); while (PREADY !== 1'b1);
		rdat = PRDATA;
		err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		`CHK(rdat, e)
	endtask

	task settle(input int k);
		repeat (k) @(negedge CORE_CLK);
	endtask

	// length of the next full high half of the excitation
	task hi_len;
		while (EXCITATION_PHASE !== 1'b0) settle(1);
		while (EXCITATION_PHASE !== 1'b1) settle(1);
		for (n = 0; EXCITATION_PHASE === 1'b1; n++) settle(1);
	endtask

	task t_regs;
		rd(8'h00, 0);
		rd(8'h04, 0);
		rd(8'h1c, 0);
		wr(8'h10, 32'h3f);
		rd(8'h10, 0);
		rd(8'h24, 0);
		`CHK(err, 1'b1)
		$display("regs done");
	endtask

	task t_dc;
		wr(8'h0c, 32'hff);
		wr(8'h08, 32'h3f);
		off_mask <= 6'h05;
		settle(4);
		`CHK(PIN_DC_INJECT, 6'h3f)
		`CHK(DC_DETECT_EN, 1'b1)
		`CHK(CURRENT_DAC_CODE, 8'hff)
		rd(8'h10, 32'h05);
		rd(8'h14, 32'h05);
		wr(8'h1c, 32'h01);
		settle(2);
		`CHK(IRQ, 1'b1)
		wr(8'h1c, 32'h02);
		settle(2);
		`CHK(IRQ, 1'b0)
		wr(8'h18, 32'h3f);
		rd(8'h14, 0);
		$display("dc and irq done");
	endtask

	task t_ana;
		wr(8'h04, 0);
		wr(8'h00, 32'h1e);
		off_mask <= 6'h02;
		settle(4);
		`CHK(THRESHOLD_DAC_LEVEL, 2'h3)
		`CHK(AC_DETECT_EN, 1'b1)
		hi_len;
		`CHK(n, 800)
		settle(400);
		`CHK(PIN_SINK, 6'h3f)
		settle(800);
		`CHK(PIN_SOURCE, 6'h3f)
		rd(8'h10, 32'h02);
		wr(8'h04, 32'h02);
		hi_len;
		`CHK(n, 2400)
		wr(8'h04, 32'h80);
		hi_len;
		`CHK(n, 12800)
		$display("analog done");
	endtask

	task t_dig;
		wr(8'h04, 0);
		wr(8'h00, 32'h02);
		wr(8'h08, 32'h16);
		while (EXCITATION_PHASE !== 1'b1) settle(1);
		settle(400);
		`CHK(CH_POS_SOURCE, 3'b100)
		`CHK(CH_POS_SINK, 3'b010)
		`CHK(CH_NEG_SOURCE, 3'b010)
		`CHK(CH_NEG_SINK, 3'b100)
		`CHK(PIN_SOURCE, 6'h00)
		$display("digital done");
	endtask

	task t_shdn;
		wr(8'h00, 32'h07);
		settle(3);
		`CHK(CURRENT_DAC_CODE, 8'h00)
		`CHK({CH_POS_SOURCE, CH_POS_SINK, AC_DETECT_EN, DC_DETECT_EN}, 8'h00)
		rd(8'h10, 0);
		$display("shutdown done");
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge CORE_CLK);
		RESETN <= 1;
		t_regs;
		t_dc;
		t_ana;
		t_dig;
		t_shdn;
		finish_test;
	end
endmodule

bind acl_top acl_chk acl_chk_i (.CORE_CLK, .RESETN, .PSEL, .PENABLE, .PREADY, .PSLVERR, .PIN_SOURCE,
	.PIN_SINK, .CH_POS_SOURCE, .CH_POS_SINK, .CH_NEG_SOURCE, .CH_NEG_SINK, .AC_DETECT_EN, .DC_DETECT_EN,
	.EXCITATION_PHASE);

`default_nettype wire
